// ### hdl/pis_pkg.sv
// Purpose: Shared constants for the period interrupt and source select block
// Assumes: APB with 32-bit data, register byte address is four times the index
// Notes:   Register indices keep the printed offsets, the bus word is index * 4
package pis_pkg;
  // Register indices
  localparam logic [10:0] IDX_ERS  = 11'h460; // ext_reset_source_select
  localparam logic [10:0] IDX_CLK  = 11'h461; // timer_clock_source_select
  localparam logic [10:0] IDX_LDS  = 11'h462; // autoload_trigger_select
  localparam logic [10:0] IDX_PR   = 11'h463; // period_register
  localparam logic [10:0] IDX_POS  = 11'h466; // period_postscale_value
  localparam logic [10:0] IDX_GIR  = 11'h467; // slice_param_flags
  localparam logic [10:0] IDX_GIE  = 11'h468; // slice_param_enables
  localparam logic [10:0] IDX_CON  = 11'h469; // module enable
  localparam logic [10:0] IDX_IRQ  = 11'h46a; // interrupt flags and enables

  // Field positions
  localparam int CON_EN_BIT   = 7;
  localparam int IRQ_PIF_BIT  = 0;
  localparam int IRQ_PIE_BIT  = 1;
  localparam int IRQ_SUMF_BIT = 2;
  localparam int IRQ_SUME_BIT = 3;

  // Reset values
  localparam logic [3:0]  RST_SEL  = 4'h0;
  localparam logic [15:0] RST_PR   = 16'h0000;
  localparam logic [7:0]  RST_POS  = 8'h00;
  localparam logic [1:0]  RST_GI   = 2'h0;

  // External reset source codes
  localparam logic [3:0] ERS_OFF   = 4'h0;
  localparam logic [3:0] ERS_PIN   = 4'h1;
  localparam logic [3:0] ERS_SL_LO = 4'h2;
  localparam logic [3:0] ERS_SL_HI = 4'h7;
  localparam logic [3:0] ERS_LC_LO = 4'h8;
  localparam logic [3:0] ERS_LC_HI = 4'hb;

  // Clock source codes
  localparam logic [3:0] CLK_PIN1  = 4'h1;
  localparam logic [3:0] CLK_SYS   = 4'h2;
  localparam logic [3:0] CLK_OSC_HI = 4'h8;
  localparam logic [3:0] CLK_RSVD  = 4'hf;

  // Auto-load trigger codes
  localparam logic [3:0] LDS_PIN0  = 4'h1;
  localparam logic [3:0] LDS_PIN1  = 4'h2;
  localparam logic [3:0] LDS_LC_LO = 4'h3;
  localparam logic [3:0] LDS_LC_HI = 4'h6;
  localparam logic [3:0] LDS_DMA_LO = 4'h7;
  localparam logic [3:0] LDS_DMA_HI = 4'ha;
endpackage : pis_pkg

// ### hdl/pis_top.sv
// Purpose: Period interrupt, postscaler, slice flag summary and source selects
// Assumes: clk_i is the selected timer clock; it stops when its source stops
// Notes:   Slice parameter events arrive as one-cycle pulses from the slices
// What this block does
// - Timer matching period value raises period event and returns timer to zero.
// - Period flag sets on each postscaled interrupt, stays until software clears.
// - Period flag reaches interrupt output only while its enable is set.
// - Postscaler passes one period interrupt per programmed count, 1:1 to 1:256.
// - Postscale value writes act on the comparison immediately.
// - Clearing module enable returns postscale counter to its initial count.
// - Each slice has two parameter flags, each with its own enable bit.
// - Summary flag is OR of enabled slice parameter flags, read only.
// - Summary flag drops once no set slice flag still has its enable bit set.
// - Summary flag reaches interrupt output only while summary enable is set.
// - Counting needs a running timer clock; without it everything halts.
// - External reset source code selects pin, other slices, logic cells.
// - Clock source code selects pins, system clock, oscillators, logic cells.
// - System clock stops in sleep, oscillators run, derived sources follow origin.
// - Auto-load trigger code selects pins, logic cells or DMA count done.
// - Period value is 16-bit read-write, reset zero, two byte fields.
// - One period interrupt after postscale value plus one period events.
// - Slice parameter flags set on the slice's mode-dependent events.
// - Clearing enable resets internal logic, keeps register contents.
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
module pis_top
  import pis_pkg::*;
#(
  parameter int INSTANCE = 1 // Instance number 1 to 3
) (
  input  wire logic        clk_i,           // Selected timer clock
  input  wire logic        nrst_i,          // Synchronous reset, active low
  input  wire logic        psel_i,          // APB select
  input  wire logic        penable_i,       // APB access phase
  input  wire logic        pwrite_i,        // APB write
  input  wire logic [12:0] paddr_i,         // APB byte address
  input  wire logic [31:0] pwdata_i,        // APB write data
  output logic      [31:0] prdata_o,        // APB read data
  output logic             pready_o,        // APB ready
  output logic             pslverr_o,       // APB error, unmapped address
  input  wire logic [15:0] period_buf_i,    // Buffered period value
  output logic      [15:0] period_value_o,  // Period register to buffer logic
  output logic      [15:0] timer_o,         // Period timer value
  output logic             period_evt_o,    // Period match event
  output logic             module_en_o,     // Module enable
  input  wire logic [1:0]  slice_evt_i,     // Parameter one/two events
  output logic             period_irq_o,    // Period interrupt request
  output logic             summary_irq_o,   // Summary interrupt request
  input  wire logic        reset_pin_i,     // Instance reset pin input
  input  wire logic [5:0]  slice_outs_i,    // Other slices, codes 2 to 7
  input  wire logic [3:0]  logic_cell_i,    // Logic cell outputs
  output logic             ext_reset_o,     // Selected external reset level
  input  wire logic        pin_clk0_i,      // Pin clock input zero
  input  wire logic        pin_clk1_i,      // Pin clock input one
  input  wire logic [3:0]  dma_done_i,      // DMA destination count done
  output logic             autoload_o,      // Selected auto-load trigger
  output logic      [3:0]  clk_sel_o,       // Timer clock source select
  input  wire logic        sleep_i,         // Device in sleep
  input  wire logic        origin_runs_i,   // Derived source origin runs in sleep
  output logic             clk_sleep_ok_o   // Selected clock runs now
);

  // Codes naming this instance's own slice outputs are reserved
  function automatic logic ers_own(input logic [3:0] code);
    logic [3:0] lo;
    lo = 4'(2 * INSTANCE);
    ers_own = (code == lo) || (code == lo + 4'h1);
  endfunction : ers_own

  // Software writes zero to clear a flag; hardware set always wins
  function automatic logic [1:0] flag_next(input logic [1:0] cur, input logic [1:0] set,
                                           input logic clr_wr, input logic [1:0] wd);
    flag_next = set | (clr_wr ? (cur & wd) : cur);
  endfunction : flag_next

  logic [3:0]  ers_sel;
  logic [3:0]  clk_sel;
  logic [3:0]  lds_sel;
  logic [15:0] period_value;
  logic [7:0]  postscale;
  logic [1:0]  slice_flags;
  logic [1:0]  slice_en;
  logic        enable;
  logic        pif;
  logic        pie;
  logic        sum_en;
  logic [15:0] timer;
  logic [7:0]  post_cnt;
  logic [2:0]  pin_s1;
  logic [2:0]  pin_s2;
  logic [31:0] rdata;

  // Bus decode
  wire         idx_ok   = paddr_i[1:0] == 2'h0;  // Word aligned accesses only
  wire  [10:0] idx      = paddr_i[12:2];
  wire         hit_ers  = idx_ok && idx == IDX_ERS;
  wire         hit_clk  = idx_ok && idx == IDX_CLK;
  wire         hit_lds  = idx_ok && idx == IDX_LDS;
  wire         hit_pr   = idx_ok && idx == IDX_PR;
  wire         hit_pos  = idx_ok && idx == IDX_POS;
  wire         hit_gir  = idx_ok && idx == IDX_GIR;
  wire         hit_gie  = idx_ok && idx == IDX_GIE;
  wire         hit_con  = idx_ok && idx == IDX_CON;
  wire         hit_irq  = idx_ok && idx == IDX_IRQ;
  wire         mapped   = hit_ers | hit_clk | hit_lds | hit_pr | hit_pos |
                          hit_gir | hit_gie | hit_con | hit_irq;
  wire         setup    = psel_i && !penable_i;
  wire         access   = psel_i && penable_i;
  wire         wr       = access && pwrite_i && mapped;

  // Period match and postscaler; clk_i stopping halts all of it
  wire         period_evt = enable && (timer == period_buf_i);
  wire         post_hit   = post_cnt == postscale;
  wire         post_irq   = period_evt && post_hit;
  wire         summary    = |(slice_flags & slice_en);
  wire         slice_wr   = wr && hit_gir;
  wire         irq_wr     = wr && hit_irq;
  wire  [1:0]  next_flags = flag_next(slice_flags, slice_evt_i, slice_wr,
                                      pwdata_i[1:0]);
  wire         next_pif   = post_irq | (pif & ~(irq_wr & ~pwdata_i[IRQ_PIF_BIT]));

  // Read mux, reserved bits read zero
  always_comb begin
    rdata = 32'h0000_0000;
    if (hit_ers) rdata[3:0] = ers_sel;
    if (hit_clk) rdata[3:0] = clk_sel;
    if (hit_lds) rdata[3:0] = lds_sel;
    if (hit_pr)  rdata[15:0] = period_value;
    if (hit_pos) rdata[7:0] = postscale;
    if (hit_gir) rdata[1:0] = slice_flags;
    if (hit_gie) rdata[1:0] = slice_en;
    if (hit_con) rdata[CON_EN_BIT] = enable;
    if (hit_irq) rdata[3:0] = {sum_en, summary, pie, pif};
  end

  // Read data captured in setup so the access phase needs no wait
  always_ff @(posedge clk_i) begin
    if (!nrst_i) prdata_o <= 32'h0000_0000;
    else if (setup) prdata_o <= rdata;
  end

  assign pready_o  = 1'b1;
  assign pslverr_o = access && !mapped;

  // Software registers; contents survive a module disable
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      ers_sel      <= RST_SEL;
      clk_sel      <= RST_SEL;
      lds_sel      <= RST_SEL;
      period_value <= RST_PR;
      postscale    <= RST_POS;
      slice_en     <= RST_GI;
      enable       <= 1'b0;
      pie          <= 1'b0;
      sum_en       <= 1'b0;
    end else if (wr) begin
      if (hit_ers) ers_sel <= pwdata_i[3:0];
      if (hit_clk) clk_sel <= pwdata_i[3:0];
      if (hit_lds) lds_sel <= pwdata_i[3:0];
      if (hit_pr)  period_value <= pwdata_i[15:0];
      if (hit_pos) postscale <= pwdata_i[7:0];
      if (hit_gie) slice_en <= pwdata_i[1:0];
      if (hit_con) enable <= pwdata_i[CON_EN_BIT];
      if (hit_irq) begin
        pie    <= pwdata_i[IRQ_PIE_BIT];
        sum_en <= pwdata_i[IRQ_SUME_BIT];
      end
    end
  end

  // Flags keep their state across disable
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      slice_flags <= RST_GI;
      pif         <= 1'b0;
    end else begin
      slice_flags <= next_flags;
      pif         <= next_pif;
    end
  end

  // Timer and postscale counter cleared while disabled
  always_ff @(posedge clk_i) begin
    if (!nrst_i || !enable) begin
      timer    <= 16'h0000;
      post_cnt <= 8'h00;
    end else if (period_evt) begin
      timer    <= 16'h0000;
      post_cnt <= post_hit ? 8'h00 : post_cnt + 8'h01;
    end else begin
      timer    <= timer + 16'h0001;
    end
  end

  // Pin synchronisers
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      pin_s1 <= 3'h0;
      pin_s2 <= 3'h0;
    end else begin
      pin_s1 <= {pin_clk1_i, pin_clk0_i, reset_pin_i};
      pin_s2 <= pin_s1;
    end
  end

  // External reset source; own slice codes and high codes disabled
  wire ers_slice = ers_sel >= ERS_SL_LO && ers_sel <= ERS_SL_HI && !ers_own(ers_sel);
  wire ers_lc    = ers_sel >= ERS_LC_LO && ers_sel <= ERS_LC_HI;
  assign ext_reset_o = (ers_sel == ERS_PIN) ? pin_s2[0] :
                       ers_slice ? slice_outs_i[ers_sel[2:0] - 3'h2] :
                       ers_lc    ? logic_cell_i[ers_sel[1:0]] :
                       1'b0;

  // Auto-load trigger source
  wire lds_lc  = lds_sel >= LDS_LC_LO && lds_sel <= LDS_LC_HI;
  wire lds_dma = lds_sel >= LDS_DMA_LO && lds_sel <= LDS_DMA_HI;
  wire [3:0] lc_idx  = lds_sel - LDS_LC_LO;
  wire [3:0] dma_idx = lds_sel - LDS_DMA_LO;
  assign autoload_o = (lds_sel == LDS_PIN0) ? pin_s2[1] :
                      (lds_sel == LDS_PIN1) ? pin_s2[2] :
                      lds_lc  ? logic_cell_i[lc_idx[1:0]] :
                      lds_dma ? dma_done_i[dma_idx[1:0]] :
                      1'b0;

  // Clock select goes to the clock mux; reserved code gives no clock
  wire clk_osc = clk_sel > CLK_SYS && clk_sel <= CLK_OSC_HI;
  wire clk_der = clk_sel <= CLK_PIN1 || (clk_sel > CLK_OSC_HI && clk_sel != CLK_RSVD);
  assign clk_sel_o      = clk_sel;
  assign clk_sleep_ok_o = !sleep_i ? (clk_sel != CLK_RSVD) :
                          clk_osc || (clk_der && origin_runs_i);

  // Outputs
  assign period_value_o = period_value;
  assign timer_o        = timer;
  assign period_evt_o   = period_evt;
  assign module_en_o    = enable;
  assign period_irq_o   = pif & pie;
  assign summary_irq_o  = summary & sum_en;

  // Assertions
  sequence s_post_last;
    period_evt && post_cnt == postscale;
  endsequence

  sequence s_flag_set;
    ##1 pif;
  endsequence

  period_wrap_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    period_evt && enable |=> timer == 16'h0000)
    else $error("timer not cleared after period event");

  pif_set_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_post_last |-> s_flag_set)
    else $error("period flag not set by postscaled event");

  pif_hold_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    pif && !irq_wr |=> pif)
    else $error("period flag dropped without clear");

  pirq_gate_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    period_irq_o == (pif && pie))
    else $error("period irq gating wrong");

  post_sup_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    period_evt && post_cnt != postscale && !irq_wr && !pif |=> !pif)
    else $error("period flag set before postscale count");

  post_step_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    enable && period_evt && post_cnt != postscale ##1 enable
    |-> post_cnt == $past(post_cnt) + 8'h01)
    else $error("postscale counter did not advance");

  en_clr_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !enable |=> post_cnt == 8'h00 && timer == 16'h0000)
    else $error("counters not cleared while disabled");

  slice_set_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    slice_evt_i[0] |=> slice_flags[0])
    else $error("slice flag one lost");

  sum_or_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    summary_irq_o == (sum_en && |(slice_flags & slice_en)))
    else $error("summary irq wrong");

  reserved_ers_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ers_sel > ERS_LC_HI || ers_sel == ERS_OFF |-> !ext_reset_o)
    else $error("disabled reset source drives reset");

  pr_write_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    wr && hit_pr |=> period_value == $past(pwdata_i[15:0]))
    else $error("period register write lost");

  pr_keep_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !(wr && hit_pr) |=> $stable(period_value))
    else $error("period register changed without write");

  pos_write_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    wr && hit_pos |=> postscale == $past(pwdata_i[7:0]))
    else $error("postscale value write lost");

  // Software clear paths
  sequence s_pif_clear;
    irq_wr && !pwdata_i[IRQ_PIF_BIT] && !post_irq;
  endsequence

  sequence s_slice_clear;
    slice_wr && !pwdata_i[0] && !slice_evt_i[0];
  endsequence

  pif_clr_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_pif_clear |=> !pif)
    else $error("period flag not cleared by software");

  slice_clr_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_slice_clear |=> !slice_flags[0])
    else $error("slice flag one not cleared by software");

  slice_set2_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    slice_evt_i[1] |=> slice_flags[1])
    else $error("slice flag two lost");

  sum_drop_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    slice_flags == 2'h0 |-> !summary_irq_o)
    else $error("summary irq with no slice flag");

  sumf_read_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    setup && hit_irq |=> prdata_o[IRQ_SUMF_BIT] == $past(summary))
    else $error("summary flag read back wrong");

  // Source select guards
  ers_pin_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ers_sel == ERS_PIN |-> ext_reset_o == pin_s2[0])
    else $error("reset pin not selected");

  ers_own_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ers_own(ers_sel) |-> !ext_reset_o)
    else $error("own slice code drives reset");

  lds_off_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    lds_sel < LDS_PIN0 || lds_sel > LDS_DMA_HI |-> !autoload_o)
    else $error("disabled auto-load code drives trigger");

  clk_rsvd_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    clk_sel == CLK_RSVD |-> !clk_sleep_ok_o)
    else $error("reserved clock code reports a clock");

  sys_sleep_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    sleep_i && clk_sel == CLK_SYS |-> !clk_sleep_ok_o)
    else $error("system clock reported running in sleep");

endmodule : pis_top

// ### tb/pis_testbench.sv
// Purpose: Self-checking bench for the period interrupt and source select block
// Assumes: APB byte address is four times the register index; slave is zero-wait
// Notes:   The bench drives the period buffer in place of the buffer logic
`timescale 1ns/1ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin fail_count++; \
  $display("mismatch t=%0t got=%0h exp=%0h", $time, got, exp); end end
module testbench
  import pis_pkg::*;
;
  // Stimulus, all given a value at time zero
  logic        clk_i = 1'b0, nrst_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [12:0] paddr_i = 13'h0000;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic [15:0] period_buf_i = 16'h0009;
  logic [1:0]  slice_evt_i = 2'h0;
  logic        reset_pin_i = 1'b0, pin_clk0_i = 1'b0, pin_clk1_i = 1'b0;
  logic [5:0]  slice_outs_i = 6'h00;
  logic [3:0]  logic_cell_i = 4'h0, dma_done_i = 4'h0;
  logic        sleep_i = 1'b0, origin_runs_i = 1'b0;
  // Observed outputs
  logic [31:0] prdata_o, rd;
  logic [15:0] period_value_o, timer_o;
  logic [3:0]  clk_sel_o;
  logic        pready_o, pslverr_o, period_evt_o, module_en_o, period_irq_o, err;
  logic        summary_irq_o, ext_reset_o, autoload_o, clk_sleep_ok_o;
  int          fail_count = 0, tests_run = 0;

  // 10 MHz timer clock
  always #50 clk_i = ~clk_i;

  pis_top #(.INSTANCE(1)) u_pis_top (.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .period_buf_i(period_buf_i), .period_value_o(period_value_o), .timer_o(timer_o),
    .period_evt_o(period_evt_o), .module_en_o(module_en_o), .slice_evt_i(slice_evt_i),
    .period_irq_o(period_irq_o), .summary_irq_o(summary_irq_o), .reset_pin_i(reset_pin_i),
    .slice_outs_i(slice_outs_i), .logic_cell_i(logic_cell_i), .ext_reset_o(ext_reset_o),
    .pin_clk0_i(pin_clk0_i), .pin_clk1_i(pin_clk1_i), .dma_done_i(dma_done_i),
    .autoload_o(autoload_o), .clk_sel_o(clk_sel_o), .sleep_i(sleep_i),
    .origin_runs_i(origin_runs_i), .clk_sleep_ok_o(clk_sleep_ok_o));

  task automatic results;
    if (fail_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results

  // One APB transfer; evt pulses slice events during the access cycle
  task automatic apb(input logic wr, input logic [10:0] idx, input logic [31:0] wd,
                     input logic [1:0] evt);
    int n;
    n = 0;
    @(posedge clk_i);
    psel_i <= 1'b1; penable_i <= 1'b0; pwrite_i <= wr; pwdata_i <= wd;
    paddr_i <= {idx, 2'b00};
    @(posedge clk_i);
    penable_i <= 1'b1; slice_evt_i <= evt;
    do begin @(posedge clk_i); n++; end while (pready_o !== 1'b1 && n < 20);
    if (n >= 20) begin fail_count++; results(); end
    rd = prdata_o; err = pslverr_o;
    psel_i <= 1'b0; penable_i <= 1'b0; slice_evt_i <= 2'h0;
    @(negedge clk_i); // Let the write land before anyone looks
  endtask : apb

  task automatic wr(input logic [10:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d, 2'h0);
  endtask : wr

  // Waits for a period match, bounded, and checks the timer wrap
  task automatic wait_evt;
    int n;
    n = 0;
    do begin @(negedge clk_i); n++; end while (period_evt_o !== 1'b1 && n < 200);
    if (n >= 200) begin fail_count++; results(); end
    `CHK(timer_o, period_buf_i);
    @(negedge clk_i);
    `CHK(timer_o, 16'h0000);
  endtask : wait_evt

  task automatic pulse(input logic [1:0] e);
    @(posedge clk_i) slice_evt_i <= e;
    @(posedge clk_i) slice_evt_i <= 2'h0;
    @(negedge clk_i);
  endtask : pulse

  // Reference decodes of the three selectors from the bench's own inputs
  function automatic logic ers_ref(input int c);
    if (c == 1) return reset_pin_i;
    if (c >= 4 && c <= 7) return slice_outs_i[c-2]; // Codes 2, 3 name this instance
    if (c >= 8 && c <= 11) return logic_cell_i[c-8];
    return 1'b0;
  endfunction : ers_ref

  function automatic logic lds_ref(input int c);
    if (c == 1) return pin_clk0_i;
    if (c == 2) return pin_clk1_i;
    if (c >= 3 && c <= 6) return logic_cell_i[c-3];
    if (c >= 7 && c <= 10) return dma_done_i[c-7];
    return 1'b0;
  endfunction : lds_ref

  function automatic logic ok_ref(input int c, input logic s, input logic o);
    if (c == 15) return 1'b0;
    if (!s || (c >= 3 && c <= 8)) return 1'b1;
    return (c == 2) ? 1'b0 : o;
  endfunction : ok_ref

  task automatic t_regs;
    logic [10:0] idx [9] = '{IDX_ERS, IDX_CLK, IDX_LDS, IDX_PR, IDX_POS, IDX_GIR, IDX_GIE,
                            IDX_CON, IDX_IRQ};
    foreach (idx[i]) begin apb(1'b0, idx[i], 32'h0, 2'h0); `CHK(rd, 32'h0); end
    wr(IDX_PR, 32'hdead_a55a);
    apb(1'b0, IDX_PR, 32'h0, 2'h0);
    `CHK(rd[15:0], 16'ha55a);
    `CHK(period_value_o, 16'ha55a);
    apb(1'b0, 11'h464, 32'h0, 2'h0); // Unmapped place
    `CHK({err, rd}, {1'b1, 32'h0});
  endtask : t_regs

  // Runs pos+1 period events and expects the interrupt on the last only
  task automatic post_run(input logic [7:0] pos);
    wr(IDX_POS, {24'h0, pos}); // written while disabled
    wr(IDX_IRQ, 32'h1 << IRQ_PIE_BIT);
    wr(IDX_CON, 32'h1 << CON_EN_BIT);
    for (int k = 1; k <= pos + 1; k++) begin
      wait_evt();
      `CHK(period_irq_o, 1'(k == pos + 1));
    end
    wr(IDX_CON, 32'h0);
    wr(IDX_IRQ, 32'h1 << IRQ_PIE_BIT); // Flag bit written 0 clears it
    `CHK(period_irq_o, 1'b0);
  endtask : post_run

  task automatic t_period;
    wr(IDX_POS, 32'h0);
    wr(IDX_CON, 32'h1 << CON_EN_BIT);
    wait_evt();
    `CHK(period_irq_o, 1'b0);
    wr(IDX_CON, 32'h0);
    @(negedge clk_i); // Timer clears at the edge after enable drops
    `CHK({module_en_o, timer_o}, 17'h0);
    apb(1'b0, IDX_IRQ, 32'h0, 2'h0);
    `CHK(rd[IRQ_PIF_BIT], 1'b1);
    wr(IDX_IRQ, 32'h3); // Enable, flag kept
    `CHK(period_irq_o, 1'b1);
    post_run(8'h00);
    post_run(8'h02);
    post_run(8'hff);
    // Disable part way through a postscale count
    wr(IDX_POS, 32'h2);
    wr(IDX_CON, 32'h1 << CON_EN_BIT);
    wait_evt();
    wait_evt();
    wr(IDX_CON, 32'h0);
    post_run(8'h02);
  endtask : t_period

  task automatic t_slice;
    wr(IDX_GIE, 32'h3);
    wr(IDX_IRQ, 32'h1 << IRQ_SUME_BIT);
    pulse(2'h1);
    `CHK(summary_irq_o, 1'b1);
    apb(1'b0, IDX_GIR, 32'h0, 2'h0);
    `CHK(rd[1:0], 2'h1);
    wr(IDX_GIR, 32'h2);
    `CHK(summary_irq_o, 1'b0);
    wr(IDX_GIE, 32'h2);
    pulse(2'h1);
    `CHK(summary_irq_o, 1'b0);
    wr(IDX_GIE, 32'h3);
    `CHK(summary_irq_o, 1'b1);
    wr(IDX_IRQ, 32'h0); // Summary enable off, summary bit written 0
    `CHK(summary_irq_o, 1'b0);
    pulse(2'h2);
    wr(IDX_GIR, 32'h1);
    apb(1'b0, IDX_IRQ, 32'h0, 2'h0);
    `CHK(rd[IRQ_SUMF_BIT], 1'b1);
    wr(IDX_GIR, 32'h0);
    apb(1'b0, IDX_IRQ, 32'h0, 2'h0);
    `CHK(rd[IRQ_SUMF_BIT], 1'b0);
    apb(1'b1, IDX_GIR, 32'h0, 2'h2); // Event lands with the clear
    apb(1'b0, IDX_GIR, 32'h0, 2'h0);
    `CHK(rd[1:0], 2'h2);
  endtask : t_slice

  task automatic t_select;
    for (int c = 0; c < 16; c++) begin
      wr(IDX_ERS, c); wr(IDX_CLK, c); wr(IDX_LDS, c);
      `CHK(clk_sel_o, 4'(c));
      for (int p = 0; p < 2; p++) begin
        @(posedge clk_i);
        reset_pin_i <= p[0]; pin_clk0_i <= p[0]; pin_clk1_i <= !p[0];
        slice_outs_i <= p[0] ? 6'h15 : 6'h2a; logic_cell_i <= p[0] ? 4'h5 : 4'ha;
        dma_done_i <= p[0] ? 4'h6 : 4'h9;
        repeat (3) @(posedge clk_i); // Pins pass a two-flop synchroniser
        @(negedge clk_i);
        `CHK(ext_reset_o, ers_ref(c));
        `CHK(autoload_o, lds_ref(c));
      end
      for (int s = 0; s < 4; s++) begin
        @(posedge clk_i) {sleep_i, origin_runs_i} <= 2'(s);
        @(negedge clk_i);
        `CHK(clk_sleep_ok_o, ok_ref(c, sleep_i, origin_runs_i));
      end
    end
  endtask : t_select

  // Main sequence: reset for 20 cycles, then each scenario in turn
  initial begin
    repeat (20) @(posedge clk_i);
    nrst_i <= 1'b1;
    t_regs();
    t_period();
    t_slice();
    t_select();
    results();
  end
endmodule : testbench
